// ### rx_strap_pkg.sv
// constants and types shared by the strapped receiver control logic
package rx_strap_pkg;

  // clock and timing
  localparam int CLK_MHZ          = 250;
  localparam int RST_TO_RX_MS     = 20;
  localparam int RST_TO_RX_CYCLES = RST_TO_RX_MS * 1000 * CLK_MHZ;
  localparam int WAKE_TIME_US     = 500;
  localparam int WAKE_CYCLES      = WAKE_TIME_US * CLK_MHZ;
  localparam int PWR_OFF_US       = 100;
  localparam int PWR_OFF_CYCLES   = PWR_OFF_US * CLK_MHZ;
  localparam int TIMER_W          = 23;

  // strap probing: four phases of 32 cycles each
  localparam int PHASE_W     = 5;
  localparam int STRAP_CNT_W = 7;
  localparam int NUM_SENSE   = 5;

  typedef enum logic [1:0] {
    STRAP_GND = 2'h0,
    STRAP_VDD = 2'h1,
    STRAP_PB  = 2'h2,
    STRAP_PA  = 2'h3
  } strap_t;

  // sampled level over the four phases, oldest first
  localparam logic [3:0] PAT_GND = 4'h0;
  localparam logic [3:0] PAT_VDD = 4'hf;
  localparam logic [3:0] PAT_PA  = 4'h3;
  localparam logic [3:0] PAT_PB  = 4'h5;

  typedef enum logic [2:0] {
    ST_PWROFF = 3'h0,
    ST_STRAP  = 3'h1,
    ST_LOAD   = 3'h2,
    ST_BOOT   = 3'h3,
    ST_RX     = 3'h4,
    ST_STANDBY_TOGGLE   = 3'h5,
    ST_WAKE   = 3'h6
  } mode_state_t;

  // preloaded configuration tables
  localparam logic [2:0] FREQ_315     = 3'h1;
  localparam logic [2:0] FREQ_HI_BASE = 3'h3;
  localparam int         NUM_FREQ     = 6;
  localparam logic [19:0] CARRIER_KHZ [0:NUM_FREQ-1] = '{
    20'h69f00, 20'h4ce78, 20'h69fe6, 20'hd3e00, 20'hd3fcc, 20'hdfe08
  };
  localparam logic [3:0]  MODEM_DVDD_BASE = 4'h4;
  localparam logic [3:0]  MODEM_DPB_BASE  = 4'h6;
  localparam logic [3:0]  MODEM_DPA_BASE  = 4'ha;
  localparam logic [12:0] FSK_MASK        = 13'h1fc0;
  localparam logic [12:0] SQUELCH_MASK    = 13'h1800;

  // clock output synthesis: toggle on accumulator wrap
  localparam int         NCO_W       = 8;
  localparam logic [7:0] NCO_MOD     = 8'hfa;
  localparam logic [7:0] STEP_10MHZ  = 8'h14;
  localparam logic [7:0] STEP_15MHZ  = 8'h1e;

  // register map
  localparam logic [7:0]  ADR_STATUS  = 8'h00;
  localparam logic [7:0]  ADR_CONFIG  = 8'h04;
  localparam logic [7:0]  ADR_CONTROL = 8'h08;
  localparam logic [31:0] CTRL_RESET  = 32'h0;
  localparam int          CTRL_CLK_OFF = 0;

endpackage

// ### input_sync.sv
// three-stage synchroniser; output follows once stages two and three agree
`timescale 1ns/1ns
module input_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  // asynchronous inputs and filtered result
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] stable_out
);

  logic [WIDTH-1:0] s1_ff;
  logic [WIDTH-1:0] s2_ff;
  logic [WIDTH-1:0] s3_ff;
  logic [WIDTH-1:0] agree;

  assign agree = s2_ff ~^ s3_ff;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s1_ff      <= '0;
      s2_ff      <= '0;
      s3_ff      <= '0;
      stable_out <= '0;
    end else begin
      s1_ff      <= async_in;
      s2_ff      <= s1_ff;
      s3_ff      <= s2_ff;
      stable_out <= (agree & s3_ff) | (~agree & stable_out);
    end
  end

endmodule

// ### clk_nco.sv
// fractional divider producing a gated square wave from the system clock
`timescale 1ns/1ns
module clk_nco (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_n_in,
  // control
  input  wire logic       run_in,
  input  wire logic [7:0] step_in,
  // generated clock
  output logic            clk_out
);

  logic [rx_strap_pkg::NCO_W-1:0] acc_ff;
  logic [rx_strap_pkg::NCO_W:0]   sum;

  assign sum = {1'b0, acc_ff} + {1'b0, step_in};

  // two toggles per output period: rate = step/2 of the modulus
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      acc_ff  <= '0;
      clk_out <= 1'b0;
    end else if (!run_in) begin
      acc_ff  <= '0;
      clk_out <= 1'b0;
    end else if (sum >= {1'b0, rx_strap_pkg::NCO_MOD}) begin
      acc_ff  <= rx_strap_pkg::NCO_W'(sum - {1'b0, rx_strap_pkg::NCO_MOD});
      clk_out <= ~clk_out;
    end else begin
      acc_ff  <= sum[rx_strap_pkg::NCO_W-1:0];
    end
  end

endmodule

// ### strap_rx_ctrl.sv
// strap-configured receiver control: boot, mode machine, pins, registers
//
// Functional notes
// R01 - each selector decodes as ground, supply, first probe or second probe.
// R02 - straps read once at startup; preloaded configuration loaded without help.
// R03 - strap_a and strap_b pick one of six carrier frequencies.
// R04 - strap_c and strap_d pick one of thirteen OOK or FSK modem profiles.
// R05 - clock pin tied to first probe disables the clock output.
// R06 - only receive and standby; each standby toggle switches the mode.
// R07 - mode status low in receive, high in standby.
// R08 - standby keeps settings; receive resumes within 0.5 ms of toggle.
// R09 - reset cycles power then reaches receive in about 20 ms.
// R10 - clock output 10 MHz for 315 MHz carrier, else 15 MHz.
// R11 - clock stopped in standby and reset; valid only while status low.
// R12 - oversampled demodulated bits appear unclocked on the data pin.
// R13 - second probe shares the data pin, first probe the status pin.
// R14 - probes drive distinct patterns during startup sampling.
//
// The placing of the registers and the Wishbone register port are this design's own decisions.
`timescale 1ns/1ns
module strap_rx_ctrl #(
  parameter int RST_TO_RX_CYC = rx_strap_pkg::RST_TO_RX_CYCLES,
  parameter int WAKE_CYC      = rx_strap_pkg::WAKE_CYCLES,
  parameter int PWR_OFF_CYC   = rx_strap_pkg::PWR_OFF_CYCLES
) (
  // clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rst_n_in,
  // selector straps and clock pin readback
  input  wire logic        strap_a_in,
  input  wire logic        strap_b_in,
  input  wire logic        strap_c_in,
  input  wire logic        strap_d_in,
  input  wire logic        clk_sense_in,
  // mode control and demodulator bit
  input  wire logic        standby_toggle_in,
  input  wire logic        rx_demod_in,
  // shared pins
  output logic             status_pin_out,
  output logic             data_pin_out,
  output logic             clk_out_out,
  output logic             clk_oe_out,
  // power controls
  output logic             core_pwr_out,
  output logic             analog_en_out,
  // wishbone slave
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [7:0]  wb_adr_in,
  input  wire logic [31:0] wb_dat_in,
  input  wire logic [3:0]  wb_sel_in,
  output logic [31:0]      wb_dat_out,
  output logic             wb_ack_out
);

  localparam int TW = rx_strap_pkg::TIMER_W;
  localparam int SW = rx_strap_pkg::STRAP_CNT_W;

  rx_strap_pkg::mode_state_t state_ff;
  rx_strap_pkg::mode_state_t nxt_state;

  logic [TW-1:0]    timer_ff;
  logic [SW-1:0]    strap_cnt_ff;
  logic [3:0]       smp_ff [0:rx_strap_pkg::NUM_SENSE-1];
  logic [6:0]       sync_out;
  logic [4:0]       sense_s;
  logic             tog_s;
  logic             rx_s;
  logic             tog_prev_ff;
  logic             tog_fall;
  logic [1:0]       phase;
  logic             probe_a_bit;
  logic             probe_b_bit;
  logic             sample_now;
  logic             boot_state;

  logic [2:0]       freq_index_ff;
  logic [3:0]       modem_index_ff;
  logic             clk_en_ff;
  logic             cfg_err_ff;
  logic [2:0]       nxt_freq;
  logic [3:0]       nxt_modem;
  logic             nxt_err;
  logic             clk_run_ff;
  logic             clk_off_ff;
  logic [7:0]       nco_step;

  // input conditioning
  input_sync #(
    .WIDTH (7)
  ) u_sync (
    .clk_in     (sys_clk_in),
    .rst_n_in   (rst_n_in),
    .async_in   ({rx_demod_in, standby_toggle_in, clk_sense_in,
                  strap_d_in, strap_c_in, strap_b_in, strap_a_in}),
    .stable_out (sync_out)
  );

  assign sense_s = sync_out[4:0];
  assign tog_s   = sync_out[5];
  assign rx_s    = sync_out[6];

  // toggle input idles high; a falling edge is one toggle
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tog_prev_ff <= 1'b0;
    end else begin
      tog_prev_ff <= tog_s;
    end
  end

  assign tog_fall = tog_prev_ff & ~tog_s;

  assign boot_state = (state_ff == rx_strap_pkg::ST_PWROFF) ||
                      (state_ff == rx_strap_pkg::ST_STRAP) ||
                      (state_ff == rx_strap_pkg::ST_LOAD) ||
                      (state_ff == rx_strap_pkg::ST_BOOT);

  // mode machine
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      rx_strap_pkg::ST_PWROFF: begin
        if (timer_ff >= TW'(PWR_OFF_CYC - 1)) begin
          nxt_state = rx_strap_pkg::ST_STRAP; // R09
        end
      end
      rx_strap_pkg::ST_STRAP: begin
        if (strap_cnt_ff == '1) begin
          nxt_state = rx_strap_pkg::ST_LOAD; // R02
        end
      end
      rx_strap_pkg::ST_LOAD: begin
        nxt_state = rx_strap_pkg::ST_BOOT;
      end
      rx_strap_pkg::ST_BOOT: begin
        if (timer_ff >= TW'(RST_TO_RX_CYC - 1)) begin
          nxt_state = rx_strap_pkg::ST_RX; // R09
        end
      end
      rx_strap_pkg::ST_RX: begin
        if (tog_fall) begin
          nxt_state = rx_strap_pkg::ST_STANDBY_TOGGLE; // R06
        end
      end
      rx_strap_pkg::ST_STANDBY_TOGGLE: begin
        if (tog_fall) begin
          nxt_state = rx_strap_pkg::ST_WAKE; // R06
        end
      end
      rx_strap_pkg::ST_WAKE: begin
        if (tog_fall) begin
          nxt_state = rx_strap_pkg::ST_STANDBY_TOGGLE; // R06
        end else if (timer_ff >= TW'(WAKE_CYC - 1)) begin
          nxt_state = rx_strap_pkg::ST_RX; // R08
        end
      end
      default: begin
        nxt_state = rx_strap_pkg::ST_PWROFF;
      end
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_ff <= rx_strap_pkg::ST_PWROFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // boot and wake timer
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      timer_ff <= '0;
    end else if (state_ff == rx_strap_pkg::ST_STANDBY_TOGGLE) begin
      timer_ff <= '0;
    end else if (boot_state || state_ff == rx_strap_pkg::ST_WAKE) begin
      timer_ff <= timer_ff + TW'(1);
    end
  end

  // strap probing phases
  assign phase       = strap_cnt_ff[SW-1 -: 2];
  assign probe_a_bit = phase[1];
  assign probe_b_bit = phase[0];
  assign sample_now  = (state_ff == rx_strap_pkg::ST_STRAP) &&
                       (strap_cnt_ff[rx_strap_pkg::PHASE_W-1:0] == '1);

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      strap_cnt_ff <= '0;
    end else if (state_ff == rx_strap_pkg::ST_STRAP) begin
      strap_cnt_ff <= strap_cnt_ff + SW'(1);
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < rx_strap_pkg::NUM_SENSE; i++) begin
        smp_ff[i] <= '0;
      end
    end else if (sample_now) begin
      for (int i = 0; i < rx_strap_pkg::NUM_SENSE; i++) begin
        smp_ff[i] <= {smp_ff[i][2:0], sense_s[i]}; // R01
      end
    end
  end

  // map a four-phase sample to a strap state; msb flags no match
  function automatic logic [2:0] classify(input logic [3:0] p);
    logic [2:0] r;
    r = 3'h4;
    unique case (p)
      rx_strap_pkg::PAT_GND: r = {1'b0, rx_strap_pkg::STRAP_GND};
      rx_strap_pkg::PAT_VDD: r = {1'b0, rx_strap_pkg::STRAP_VDD};
      rx_strap_pkg::PAT_PB:  r = {1'b0, rx_strap_pkg::STRAP_PB};
      rx_strap_pkg::PAT_PA:  r = {1'b0, rx_strap_pkg::STRAP_PA};
      default:               r = 3'h4;
    endcase
    return r;
  endfunction

  // configuration decode
  always_comb begin
    logic [2:0] ca;
    logic [2:0] cb;
    logic [2:0] cc;
    logic [2:0] cd;
    ca = classify(smp_ff[0]); // R01
    cb = classify(smp_ff[1]);
    cc = classify(smp_ff[2]);
    cd = classify(smp_ff[3]);
    nxt_freq  = '0;
    nxt_modem = '0;
    nxt_err   = ca[2] | cb[2] | cc[2] | cd[2];
    if (ca[1:0] == rx_strap_pkg::STRAP_PA) begin
      nxt_err = 1'b1;
    end else if (cb[1:0] == rx_strap_pkg::STRAP_VDD) begin
      nxt_freq = {1'b0, ca[1:0]}; // R03
    end else if (cb[1:0] == rx_strap_pkg::STRAP_PB) begin
      nxt_freq = rx_strap_pkg::FREQ_HI_BASE + {1'b0, ca[1:0]}; // R03
    end else begin
      nxt_err = 1'b1;
    end
    unique case (cd[1:0])
      rx_strap_pkg::STRAP_GND: nxt_modem = {2'h0, cc[1:0]}; // R04
      rx_strap_pkg::STRAP_VDD: begin
        nxt_modem = rx_strap_pkg::MODEM_DVDD_BASE + {2'h0, cc[1:0]};
        if (cc[1]) begin
          nxt_err = 1'b1; // R04
        end
      end
      rx_strap_pkg::STRAP_PB:
        nxt_modem = rx_strap_pkg::MODEM_DPB_BASE + {2'h0, cc[1:0]};
      rx_strap_pkg::STRAP_PA: begin
        nxt_modem = rx_strap_pkg::MODEM_DPA_BASE + {2'h0, cc[1:0]};
        if (cc[1:0] == rx_strap_pkg::STRAP_PA) begin
          nxt_err = 1'b1; // R04
        end
      end
    endcase
    if (nxt_err) begin
      nxt_freq  = '0;
      nxt_modem = '0;
    end
  end

  // loaded once per reset, held through standby
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      freq_index_ff  <= '0;
      modem_index_ff <= '0;
      cfg_err_ff     <= 1'b0;
      clk_en_ff      <= 1'b0;
    end else if (state_ff == rx_strap_pkg::ST_LOAD) begin
      freq_index_ff  <= nxt_freq; // R02
      modem_index_ff <= nxt_modem;
      cfg_err_ff     <= nxt_err;
      clk_en_ff      <= (smp_ff[4] != rx_strap_pkg::PAT_PA); // R05
    end
  end

  // shared pins and power controls
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_pin_out <= 1'b1;
      data_pin_out   <= 1'b0;
      clk_oe_out     <= 1'b0;
      clk_run_ff     <= 1'b0;
      core_pwr_out   <= 1'b0;
      analog_en_out  <= 1'b0;
    end else begin
      if (state_ff == rx_strap_pkg::ST_STRAP) begin
        status_pin_out <= probe_a_bit; // R14
        data_pin_out   <= probe_b_bit; // R13
      end else begin
        status_pin_out <= (state_ff != rx_strap_pkg::ST_RX); // R07
        data_pin_out   <= (state_ff == rx_strap_pkg::ST_RX) & rx_s; // R12
      end
      clk_oe_out    <= clk_en_ff && !boot_state; // R05
      clk_run_ff    <= (state_ff == rx_strap_pkg::ST_RX) && clk_en_ff &&
                       !clk_off_ff; // R11
      core_pwr_out  <= (state_ff != rx_strap_pkg::ST_PWROFF); // R09
      analog_en_out <= (state_ff == rx_strap_pkg::ST_BOOT) ||
                       (state_ff == rx_strap_pkg::ST_WAKE) ||
                       (state_ff == rx_strap_pkg::ST_RX); // R08
    end
  end

  assign nco_step = (freq_index_ff == rx_strap_pkg::FREQ_315) ?
                    rx_strap_pkg::STEP_10MHZ :
                    rx_strap_pkg::STEP_15MHZ; // R10

  clk_nco u_nco (
    .clk_in   (sys_clk_in),
    .rst_n_in (rst_n_in),
    .run_in   (clk_run_ff),
    .step_in  (nco_step),
    .clk_out  (clk_out_out)
  );

  // wishbone slave, one wait state, unmapped reads return zero
  logic        wb_req;
  logic [31:0] rd_data;

  assign wb_req = wb_cyc_in && wb_stb_in && !wb_ack_out;

  always_comb begin
    rd_data = 32'h0;
    unique case (wb_adr_in)
      rx_strap_pkg::ADR_STATUS:
        rd_data = {26'h0, clk_en_ff, cfg_err_ff,
                   status_pin_out, state_ff};
      rx_strap_pkg::ADR_CONFIG:
        rd_data = {rx_strap_pkg::CARRIER_KHZ[freq_index_ff], 2'h0,
                   rx_strap_pkg::SQUELCH_MASK[modem_index_ff],
                   rx_strap_pkg::FSK_MASK[modem_index_ff],
                   modem_index_ff, 1'b0, freq_index_ff};
      rx_strap_pkg::ADR_CONTROL:
        rd_data = {31'h0, clk_off_ff};
      default:
        rd_data = 32'h0;
    endcase
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wb_ack_out <= 1'b0;
      wb_dat_out <= 32'h0;
    end else begin
      wb_ack_out <= wb_req;
      if (wb_req && !wb_we_in) begin
        wb_dat_out <= rd_data;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      clk_off_ff <= rx_strap_pkg::CTRL_RESET[rx_strap_pkg::CTRL_CLK_OFF];
    end else if (wb_cyc_in && wb_stb_in && wb_ack_out && wb_we_in &&
                 wb_sel_in[0] &&
                 wb_adr_in == rx_strap_pkg::ADR_CONTROL) begin
      clk_off_ff <= wb_dat_in[rx_strap_pkg::CTRL_CLK_OFF];
    end
  end

  // checks
  default clocking cb_sys @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);

  sequence s_rx_toggle;
    (state_ff == rx_strap_pkg::ST_RX) && tog_fall;
  endsequence

  sequence s_standby_toggle_shown;
    (state_ff == rx_strap_pkg::ST_STANDBY_TOGGLE) ##1 status_pin_out;
  endsequence

  a_rx_to_standby_toggle: assert property (s_rx_toggle |=> s_standby_toggle_shown) // R06
    else $error("toggle in receive did not reach standby");

  a_standby_toggle_to_wake: assert property ( // R06
    (state_ff == rx_strap_pkg::ST_STANDBY_TOGGLE && tog_fall) |=>
      (state_ff == rx_strap_pkg::ST_WAKE))
    else $error("toggle in standby did not start wake");

  a_status_rx_low: assert property ( // R07
    (state_ff == rx_strap_pkg::ST_RX) |=> !status_pin_out)
    else $error("status not low in receive");

  a_wake_bound: assert property ( // R08
    (state_ff == rx_strap_pkg::ST_WAKE) |-> (timer_ff < TW'(WAKE_CYC)))
    else $error("wake exceeded its time");

  a_cfg_retained: assert property ( // R08
    (!boot_state && !$past(boot_state)) |-> $stable(freq_index_ff) &&
      $stable(modem_index_ff) && $stable(clk_en_ff))
    else $error("loaded settings changed after boot");

  a_boot_bound: assert property ( // R09
    (state_ff == rx_strap_pkg::ST_BOOT) |-> (timer_ff < TW'(RST_TO_RX_CYC)))
    else $error("boot exceeded reset to receive time");

  a_clk_rx_only: assert property ( // R11
    $rose(clk_out_out) |-> !$past(status_pin_out) && $past(clk_en_ff))
    else $error("clock edge outside receive");

  a_clk_strap_off: assert property ( // R05
    (state_ff == rx_strap_pkg::ST_RX && !clk_en_ff) |-> ##2 !clk_out_out)
    else $error("clock running while strapped off");

  // slow clock half period spans more than eight system cycles
  a_step_315: assert property ( // R10
    (freq_index_ff == rx_strap_pkg::FREQ_315 && clk_run_ff &&
     $changed(clk_out_out)) |=>
      ($stable(clk_out_out) || !clk_run_ff)[*8])
    else $error("wrong clock rate for 315 carrier");

  a_probe_pattern: assert property ( // R14
    (state_ff == rx_strap_pkg::ST_STRAP) |=>
      (status_pin_out == $past(probe_a_bit)) &&
      (data_pin_out == $past(probe_b_bit)))
    else $error("probe pattern wrong during strap sampling");

  a_data_quiet: assert property ( // R12
    (state_ff == rx_strap_pkg::ST_STANDBY_TOGGLE) |=> !data_pin_out)
    else $error("data pin active in standby");

endmodule

// ### strap_board.sv
// board ties from selector inputs to supply, ground or probe pins
`timescale 1ns/1ns
module strap_board (
  // probe pins driven by the device
  input  wire logic       pa_pin_in,
  input  wire logic       pb_pin_in,
  // tie choice per selector, two bits each: a b c d clock
  input  wire logic [9:0] tie_in,
  // levels seen at the selector inputs
  output logic      [4:0] strap_out
);
  // each selector tied to exactly one source
  always_comb begin
    for (int i = 0; i < 5; i++) begin
      case (rx_strap_pkg::strap_t'(tie_in[2*i +: 2]))
        rx_strap_pkg::STRAP_GND: strap_out[i] = 1'b0;
        rx_strap_pkg::STRAP_VDD: strap_out[i] = 1'b1;
        rx_strap_pkg::STRAP_PB:  strap_out[i] = pb_pin_in;
        default:                 strap_out[i] = pa_pin_in;
      endcase
    end
  end
endmodule

// ### testbench.sv
// self-checking bench for the strapped receiver control
`timescale 1ns/1ns
module testbench;
  localparam int RST_CYC = 2000;
  localparam int WAKE    = 100;
  logic        sys_clk_in = 1'b0;
  logic        rst_n_in   = 1'b0;
  logic        toggle     = 1'b1;
  logic        demod      = 1'b0;
  logic        wb_cyc     = 1'b0;
  logic        wb_stb     = 1'b0;
  logic        wb_we      = 1'b0;
  logic [7:0]  wb_adr     = 8'h00;
  logic [31:0] wb_wdat    = 32'h0;
  logic [3:0]  wb_sel     = 4'h0;
  logic [9:0]  tie        = 10'h0;
  logic [4:0]  strap;
  logic        status_pin, data_pin, clk_o, clk_oe, core_pwr, analog_en;
  logic [31:0] wb_rdat;
  logic        wb_ack;
  int          num_errors = 0;
  int          num_checks = 0;
  int          seed       = 18;
  int          test_no    = 0;

  always #2 sys_clk_in = ~sys_clk_in;

  strap_board u_strap_board (.pa_pin_in(status_pin), .pb_pin_in(data_pin),
    .tie_in(tie), .strap_out(strap));

  strap_rx_ctrl #(.RST_TO_RX_CYC(RST_CYC), .WAKE_CYC(WAKE), .PWR_OFF_CYC(50))
  u_strap_rx_ctrl (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
    .strap_a_in(strap[0]), .strap_b_in(strap[1]), .strap_c_in(strap[2]),
    .strap_d_in(strap[3]), .clk_sense_in(strap[4]),
    .standby_toggle_in(toggle), .rx_demod_in(demod),
    .status_pin_out(status_pin), .data_pin_out(data_pin),
    .clk_out_out(clk_o), .clk_oe_out(clk_oe), .core_pwr_out(core_pwr),
    .analog_en_out(analog_en),
    .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_we_in(wb_we),
    .wb_adr_in(wb_adr), .wb_dat_in(wb_wdat), .wb_sel_in(wb_sel),
    .wb_dat_out(wb_rdat), .wb_ack_out(wb_ack));

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wb_xfer(input logic we, input logic [7:0] adr,
                         input logic [31:0] wd, output logic [31:0] rd);
    int n;
    @(posedge sys_clk_in);
    wb_cyc  <= 1'b1;
    wb_stb  <= 1'b1;
    wb_we   <= we;
    wb_adr  <= adr;
    wb_wdat <= wd;
    wb_sel  <= 4'hf;
    n = 0;
    do begin
      @(posedge sys_clk_in);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    rd = wb_rdat;
    if (n >= 50) begin
      num_errors++;
      finish_test();
    end
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask

  task automatic count_clk(input int cyc, output int cnt);
    logic prev;
    prev = clk_o;
    cnt = 0;
    repeat (cyc) begin
      @(posedge sys_clk_in);
      if (clk_o === 1'b1 && prev === 1'b0) cnt++;
      prev = clk_o;
    end
  endtask

  task automatic pulse_toggle();
    @(posedge sys_clk_in);
    toggle <= 1'b0;
    repeat (4) @(posedge sys_clk_in);
    toggle <= 1'b1;
  endtask

  // expected {fsk, modem index, freq index}
  function automatic logic [7:0] exp_cfg(logic [1:0] a, b, c, d);
    logic [3:0] m;
    logic [2:0] f;
    f = 3'(a) + ((b == rx_strap_pkg::STRAP_PB) ? 3'h3 : 3'h0);
    case (d)
      2'h0:    m = 4'(c);
      2'h1:    m = 4'h4 + 4'(c);
      2'h2:    m = 4'h6 + 4'(c);
      default: m = 4'ha + 4'(c);
    endcase
    return {m >= 4'h6, m, f};
  endfunction

  task automatic run_cfg(input logic [1:0] a, b, c, d, k, input logic err);
    int n;
    int cnt;
    logic [31:0] rd;
    logic [31:0] cfg;
    logic v;
    logic [7:0] e;
    e = err ? 8'h00 : exp_cfg(a, b, c, d);
    tie <= {k, d, c, b, a};
    rst_n_in <= 1'b0;
    repeat (8) @(posedge sys_clk_in);
    cmp({status_pin, clk_oe, core_pwr, clk_o}, 4'h8);
    rst_n_in <= 1'b1;
    repeat (300) @(posedge sys_clk_in);
    n = 300;
    while (status_pin !== 1'b0 && n < 3000) begin
      @(posedge sys_clk_in);
      n++;
    end
    cmp(n <= RST_CYC + 20 && n >= RST_CYC - 20, 1);
    wb_xfer(1'b0, 8'h00, 32'h0, rd);
    cmp({rd[4], rd[2:0]}, {err, 3'h4});
    wb_xfer(1'b0, 8'h04, 32'h0, cfg);
    cmp({cfg[8], cfg[7:4], cfg[2:0]}, e);
    cmp({clk_oe, core_pwr, analog_en},
        {k != rx_strap_pkg::STRAP_PA, 2'h3});
    count_clk(500, cnt);
    n = (k == rx_strap_pkg::STRAP_PA) ? 0 : ((e[2:0] == 3'h1) ? 20 : 30);
    cmp(cnt >= n - 1 && cnt <= n + 1, 1);
    repeat (4) begin
      v = 1'($random(seed));
      @(posedge sys_clk_in);
      demod <= v;
      repeat (8) @(posedge sys_clk_in);
      cmp(data_pin, v);
    end
    pulse_toggle();
    repeat (8) @(posedge sys_clk_in);
    cmp({status_pin, analog_en}, 2'h2);
    count_clk(100, cnt);
    cmp(cnt, 0);
    wb_xfer(1'b0, 8'h00, 32'h0, rd);
    cmp(rd[2:0], 3'h5);
    pulse_toggle();
    n = 0;
    while (status_pin !== 1'b0 && n < WAKE + 60) begin
      @(posedge sys_clk_in);
      n++;
    end
    cmp(n <= WAKE + 20, 1);
    wb_xfer(1'b0, 8'h04, 32'h0, rd);
    cmp(rd, cfg);
    test_no++;
    $display("test %0d done", test_no);
  endtask

  initial begin
    logic [31:0] rd;
    logic [1:0] a, b, c, d;
    int cnt;
    repeat (8) @(posedge sys_clk_in);
    run_cfg(2'h1, 2'h1, 2'h0, 2'h0, 2'h1, 1'b0);
    run_cfg(2'h2, 2'h2, 2'h2, 2'h3, 2'h0, 1'b0);
    run_cfg(2'h2, 2'h1, 2'h3, 2'h0, 2'h3, 1'b0);
    repeat (4) begin
      a = 2'({$random(seed)} % 3);
      b = $random(seed) ? 2'h1 : 2'h2;
      d = 2'($random(seed));
      c = 2'({$random(seed)} % (d == 2'h1 ? 2 : (d == 2'h3 ? 3 : 4)));
      run_cfg(a, b, c, d, 2'($random(seed)), 1'b0);
    end
    run_cfg(2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 1'b1);
    wb_xfer(1'b0, 8'h40, 32'h0, rd);
    cmp(rd, 32'h0);
    wb_xfer(1'b1, 8'h08, 32'h1, rd);
    wb_xfer(1'b0, 8'h08, 32'h0, rd);
    cmp(rd, 32'h1);
    count_clk(100, cnt);
    cmp(cnt, 0);
    finish_test();
  end

  initial begin
    repeat (80000) @(posedge sys_clk_in);
    num_errors++;
    finish_test();
  end
endmodule
